//--- dcs_dma_top.sv
// DMA channels with status flags, error handling and lane duplication
// Behaviour
// - Register port accepts only 32-bit accesses
// - Narrow master writes copy data to unused lanes
// - Halfword write: halfword size, both halves equal
// - Reserved address access is a channel error
// - Transfer error clears channel enable bit
// - Error sets error flag, irq if enabled
// - Half, complete, error irqs each separately enabled
// - Per channel request from peripheral or ADC
// - Read-only status register, offset 0x00, resets zero
// - Write-only flag clear register at offset 0x04
// - Four flags per channel at bits 4n..4n+3
// - Hardware sets flags, writing one clears
// - Global flag set on any channel event
`timescale 1ns/10ps
module dcs_dma_top import dcs_pkg::*; #(
    parameter int NUM_CH = 8,
    parameter int CNT_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input logic ref_clk,
    input logic resetn,
    input logic s_hsel,
    input logic [31:0] s_haddr,
    input logic [1:0] s_htrans,
    input logic s_hwrite,
    input logic [2:0] s_hsize,
    input logic [31:0] s_hwdata,
    input logic s_hready,
    output logic s_hreadyout,
    output logic s_hresp,
    output logic [31:0] s_hrdata,
    output logic [31:0] m_haddr,
    output logic [1:0] m_htrans,
    output logic m_hwrite,
    output logic [2:0] m_hsize,
    output logic [31:0] m_hwdata,
    input logic m_hready,
    input logic m_hresp,
    input logic [31:0] m_hrdata,
    input logic [NUM_CH-1:0] periph_req,
    input logic adc_req,
    output logic [NUM_CH-1:0] chan_irq
);
    localparam int CW = $clog2(NUM_CH);
    localparam logic [31:0] FLAG_MASK = 32'((64'h1 << (NUM_CH * DCS_FLAGS_PER_CH)) - 64'h1);

    dcs_ccr_type ccr_r [NUM_CH];
    logic [CNT_W-1:0] count_r [NUM_CH];
    logic [CNT_W-1:0] count_init_r [NUM_CH];
    logic [31:0] src_r [NUM_CH];
    logic [31:0] dst_r [NUM_CH];
    logic [NUM_CH-1:0] reqsel_r;
    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] flag_set;
    logic [31:0] flag_clr;
    logic [31:0] rd_word;
    dcs_slv_phase_type wr_ph_r;
    dcs_eng_state_type state_r;
    logic [CW-1:0] cur_r;
    logic [CW-1:0] pick;
    logic any_pend;
    logic [NUM_CH-1:0] pend;
    logic slv_take;
    logic slv_bad;
    logic rd_done;
    logic wr_done;
    logic eng_err;
    logic wr_ok;
    logic tc_ev;
    logic ht_ev;
    logic [CNT_W-1:0] cnt_after;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [31:0] lane_data;

    // Address helpers shared by read and write decode
    function automatic logic is_ch(input logic [7:0] a);
        is_ch = (a[7:4] >= DCS_CH_FIRST_BLOCK) && (int'(a[7:4]) < NUM_CH + int'(DCS_CH_FIRST_BLOCK));
    endfunction

    function automatic logic [CW-1:0] ch_of(input logic [7:0] a);
        ch_of = CW'(a[7:4] - DCS_CH_FIRST_BLOCK);
    endfunction

    // Bus size code of a size field, both word codes give a word
    function automatic logic [2:0] hsize_of(input logic [1:0] s);
        hsize_of = ({1'b0, s} > DCS_HSIZE_WORD) ? DCS_HSIZE_WORD : {1'b0, s};
    endfunction

    function automatic logic [31:0] ccr_word(input dcs_ccr_type c);
        logic [31:0] w;
        w = '0;
        w[DCS_CCR_EN] = c.en;
        w[DCS_CCR_TRANSFER_COMPLETE_IRQ_ENABLE] = c.transfer_complete_irq_enable;
        w[DCS_CCR_HALF_TRANSFER_IRQ_ENABLE] = c.half_transfer_irq_enable;
        w[DCS_CCR_TRANSFER_ERROR_IRQ_ENABLE] = c.transfer_error_irq_enable;
        w[DCS_CCR_SRC_INC] = c.src_inc;
        w[DCS_CCR_DST_INC] = c.dst_inc;
        w[DCS_CCR_SRC_SIZE +: 2] = c.src_size;
        w[DCS_CCR_DST_SIZE +: 2] = c.dst_size;
        w[DCS_CCR_MEM2MEM] = c.mem2mem;
        ccr_word = w;
    endfunction

    function automatic dcs_ccr_type ccr_from(input logic [31:0] w);
        dcs_ccr_type c;
        c.en = w[DCS_CCR_EN];
        c.transfer_complete_irq_enable = w[DCS_CCR_TRANSFER_COMPLETE_IRQ_ENABLE];
        c.half_transfer_irq_enable = w[DCS_CCR_HALF_TRANSFER_IRQ_ENABLE];
        c.transfer_error_irq_enable = w[DCS_CCR_TRANSFER_ERROR_IRQ_ENABLE];
        c.src_inc = w[DCS_CCR_SRC_INC];
        c.dst_inc = w[DCS_CCR_DST_INC];
        c.src_size = w[DCS_CCR_SRC_SIZE +: 2];
        c.dst_size = w[DCS_CCR_DST_SIZE +: 2];
        c.mem2mem = w[DCS_CCR_MEM2MEM];
        ccr_from = c;
    endfunction

    // Slave address phase decode
    assign slv_take = s_hsel && s_htrans[1] && s_hready;
    assign slv_bad = (s_hsize != DCS_HSIZE_WORD);

    // Register readback
    always_comb begin
        rd_word = '0;
        if (s_haddr[7:0] == DCS_OFF_STATUS) begin
            rd_word = status_r;
        end else if (s_haddr[7:0] == DCS_OFF_REQSEL) begin
            rd_word = 32'(reqsel_r);
        end else if (is_ch(s_haddr[7:0])) begin
            case (s_haddr[3:2])
                DCS_CH_REG_CCR: rd_word = ccr_word(ccr_r[ch_of(s_haddr[7:0])]);
                DCS_CH_REG_COUNT: rd_word = 32'(count_r[ch_of(s_haddr[7:0])]);
                DCS_CH_REG_SRC: rd_word = src_r[ch_of(s_haddr[7:0])];
                default: rd_word = dst_r[ch_of(s_haddr[7:0])];
            endcase
        end
    end

    // Slave response: two-cycle error for narrow accesses, else zero wait
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_hreadyout <= 1'b1;
            s_hresp <= DCS_HRESP_OKAY;
            s_hrdata <= DCS_RESET_WORD;
            wr_ph_r <= '0;
        end else begin
            wr_ph_r.valid <= slv_take && s_hwrite && !slv_bad;
            wr_ph_r.addr <= s_haddr[7:0];
            if (slv_take && slv_bad) begin
                s_hreadyout <= 1'b0;
                s_hresp <= DCS_HRESP_ERROR;
            end else if (!s_hreadyout) begin
                s_hreadyout <= 1'b1;
            end else begin
                s_hresp <= DCS_HRESP_OKAY;
            end
            if (slv_take && !s_hwrite && !slv_bad) begin
                s_hrdata <= rd_word;
            end
        end
    end

    // Request selection and fixed lowest-index priority
    always_comb begin
        pick = '0;
        for (int n = NUM_CH - 1; n >= 0; n--) begin
            pend[n] = ccr_r[n].en && (count_r[n] != '0) &&
                      (ccr_r[n].mem2mem || (reqsel_r[n] ? adc_req : periph_req[n]));
            if (pend[n]) begin
                pick = CW'(n);
            end
        end
    end
    assign any_pend = |pend;

    // Engine completion terms
    assign rd_done = (state_r == ST_RD_DATA) && m_hready;
    assign wr_done = (state_r == ST_WR_DATA) && m_hready;
    assign eng_err = (rd_done || wr_done) && m_hresp;
    assign wr_ok = wr_done && !m_hresp;
    assign cnt_after = count_r[cur_r] - 1'b1;
    assign tc_ev = wr_ok && (cnt_after == '0);
    assign ht_ev = wr_ok && (count_init_r[cur_r] > 1) && (cnt_after == (count_init_r[cur_r] >> 1));

    // Read item taken from its lanes and zero-extended
    assign fifo_in_valid = rd_done && !m_hresp;
    assign fifo_in_data = (m_hrdata >> {m_haddr[1:0], 3'h0}) &
                          ((ccr_r[cur_r].src_size == 2'h0) ? 32'h0000_00ff :
                           (ccr_r[cur_r].src_size == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff);
    assign fifo_out_ready = (state_r == ST_WR_ADDR) && (m_htrans == DCS_HTRANS_IDLE) && fifo_out_valid;

    dcs_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    dcs_lane_dup u_lane (
        .size(hsize_of(ccr_r[cur_r].dst_size)),
        .item(fifo_out_data),
        .lanes(lane_data)
    );

    // Master engine: one read then one write per item
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cur_r <= '0;
            m_haddr <= DCS_RESET_WORD;
            m_htrans <= DCS_HTRANS_IDLE;
            m_hwrite <= 1'b0;
            m_hsize <= DCS_HSIZE_WORD;
            m_hwdata <= DCS_RESET_WORD;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (any_pend) begin
                        cur_r <= pick;
                        state_r <= ST_RD_ADDR;
                    end
                end
                ST_RD_ADDR: begin
                    if (m_htrans == DCS_HTRANS_NONSEQ) begin
                        if (m_hready) begin
                            m_htrans <= DCS_HTRANS_IDLE;
                            state_r <= ST_RD_DATA;
                        end
                    end else if (!ccr_r[cur_r].en) begin
                        state_r <= ST_IDLE;
                    end else if (fifo_in_ready) begin
                        m_haddr <= src_r[cur_r];
                        m_hwrite <= 1'b0;
                        m_hsize <= hsize_of(ccr_r[cur_r].src_size);
                        m_htrans <= DCS_HTRANS_NONSEQ;
                    end
                end
                ST_RD_DATA: begin
                    if (m_hready) begin
                        state_r <= m_hresp ? ST_IDLE : ST_WR_ADDR;
                    end
                end
                ST_WR_ADDR: begin
                    if (m_htrans == DCS_HTRANS_NONSEQ) begin
                        if (m_hready) begin
                            m_htrans <= DCS_HTRANS_IDLE;
                            state_r <= ST_WR_DATA;
                        end
                    end else if (fifo_out_valid) begin
                        m_haddr <= dst_r[cur_r];
                        m_hwrite <= 1'b1;
                        m_hsize <= hsize_of(ccr_r[cur_r].dst_size);
                        m_hwdata <= lane_data;
                        m_htrans <= DCS_HTRANS_NONSEQ;
                    end
                end
                ST_WR_DATA: begin
                    if (m_hready) begin
                        m_hwrite <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Channel registers: software writes, then hardware updates
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reqsel_r <= '0;
            for (int n = 0; n < NUM_CH; n++) begin
                ccr_r[n] <= '0;
                count_r[n] <= '0;
                count_init_r[n] <= '0;
                src_r[n] <= '0;
                dst_r[n] <= '0;
            end
        end else begin
            if (wr_ph_r.valid && wr_ph_r.addr == DCS_OFF_REQSEL) begin
                reqsel_r <= s_hwdata[NUM_CH-1:0];
            end
            if (wr_ph_r.valid && is_ch(wr_ph_r.addr)) begin
                case (wr_ph_r.addr[3:2])
                    DCS_CH_REG_CCR: ccr_r[ch_of(wr_ph_r.addr)] <= ccr_from(s_hwdata);
                    DCS_CH_REG_COUNT: begin
                        count_r[ch_of(wr_ph_r.addr)] <= s_hwdata[CNT_W-1:0];
                        count_init_r[ch_of(wr_ph_r.addr)] <= s_hwdata[CNT_W-1:0];
                    end
                    DCS_CH_REG_SRC: src_r[ch_of(wr_ph_r.addr)] <= s_hwdata;
                    default: dst_r[ch_of(wr_ph_r.addr)] <= s_hwdata;
                endcase
            end
            if (eng_err) begin
                ccr_r[cur_r].en <= 1'b0;
            end
            if (wr_ok) begin
                count_r[cur_r] <= cnt_after;
                if (ccr_r[cur_r].src_inc) begin
                    src_r[cur_r] <= src_r[cur_r] + dcs_size_bytes(ccr_r[cur_r].src_size);
                end
                if (ccr_r[cur_r].dst_inc) begin
                    dst_r[cur_r] <= dst_r[cur_r] + dcs_size_bytes(ccr_r[cur_r].dst_size);
                end
            end
        end
    end

    // Flag set and clear masks, set wins over clear
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        if (eng_err) begin
            flag_set[dcs_flag_pos(int'(cur_r), DCS_FLG_TE)] = 1'b1;
        end
        if (tc_ev) begin
            flag_set[dcs_flag_pos(int'(cur_r), DCS_FLG_TC)] = 1'b1;
        end
        if (ht_ev) begin
            flag_set[dcs_flag_pos(int'(cur_r), DCS_FLG_HT)] = 1'b1;
        end
        if (eng_err || tc_ev || ht_ev) begin
            flag_set[dcs_flag_pos(int'(cur_r), DCS_FLG_GLOBAL)] = 1'b1;
        end
        if (wr_ph_r.valid && wr_ph_r.addr == DCS_OFF_CLEAR) begin
            flag_clr = s_hwdata & FLAG_MASK;
        end
        status_nxt = (status_r & ~flag_clr) | flag_set;
    end

    // Status register, writes to its offset are ignored
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_r <= DCS_RESET_WORD;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Per channel interrupt lines, each event gated by its enable
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            chan_irq <= '0;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                chan_irq[n] <= (status_nxt[dcs_flag_pos(n, DCS_FLG_TC)] && ccr_r[n].transfer_complete_irq_enable) ||
                               (status_nxt[dcs_flag_pos(n, DCS_FLG_HT)] && ccr_r[n].half_transfer_irq_enable) ||
                               (status_nxt[dcs_flag_pos(n, DCS_FLG_TE)] && ccr_r[n].transfer_error_irq_enable);
            end
        end
    end

    // Checks
    a_slv_narrow_err: assert property (@(posedge ref_clk) disable iff (!resetn)
        slv_take && slv_bad |=> (!s_hreadyout && s_hresp) ##1 (s_hreadyout && s_hresp))
        else $error("narrow register access not answered with error");
    a_half_dup: assert property (@(posedge ref_clk) disable iff (!resetn)
        (m_htrans == DCS_HTRANS_NONSEQ) && m_hwrite && (m_hsize == DCS_HSIZE_HALF) |->
        m_hwdata[31:16] == m_hwdata[15:0])
        else $error("halfword write halves differ");
    a_byte_dup: assert property (@(posedge ref_clk) disable iff (!resetn)
        (m_htrans == DCS_HTRANS_NONSEQ) && m_hwrite && (m_hsize == DCS_HSIZE_BYTE) |->
        m_hwdata == {4{m_hwdata[7:0]}})
        else $error("byte write lanes differ");
    a_err_disable: assert property (@(posedge ref_clk) disable iff (!resetn)
        eng_err |=> !ccr_r[cur_r].en && (state_r == ST_IDLE))
        else $error("channel still enabled after transfer error");
    a_err_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
        eng_err |=> status_r[dcs_flag_pos(int'(cur_r), DCS_FLG_TE)] &&
        status_r[dcs_flag_pos(int'(cur_r), DCS_FLG_GLOBAL)])
        else $error("error or global flag not set after transfer error");
    for (genvar g = 0; g < NUM_CH; g++) begin : g_irq_te
        a_irq_te_line: assert property (@(posedge ref_clk) disable iff (!resetn)
            status_r[dcs_flag_pos(g, DCS_FLG_TE)] && ccr_r[g].transfer_error_irq_enable ##1
            status_r[dcs_flag_pos(g, DCS_FLG_TE)] && ccr_r[g].transfer_error_irq_enable |-> chan_irq[g])
            else $error("enabled error flag gives no interrupt");
    end
    a_clear_one: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_ph_r.valid && (wr_ph_r.addr == DCS_OFF_CLEAR) && s_hwdata[DCS_FLG_TC] && !flag_set[DCS_FLG_TC]
        |=> !status_r[DCS_FLG_TC])
        else $error("writing one did not clear flag");
    a_status_ro: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_ph_r.valid && (wr_ph_r.addr == DCS_OFF_STATUS) && (flag_set == '0) |=> $stable(status_r))
        else $error("status register changed by a write");
    a_global_any: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(status_r[DCS_FLG_TC]) || $rose(status_r[DCS_FLG_HT]) |-> status_r[DCS_FLG_GLOBAL])
        else $error("global flag missing after channel event");
    a_dst_step: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_ok && ccr_r[cur_r].dst_inc |=> dst_r[cur_r] == $past(dst_r[cur_r]) + dcs_size_bytes(ccr_r[cur_r].dst_size))
        else $error("destination address did not advance by its width");
    c_transfer_error: cover property (@(posedge ref_clk) disable iff (!resetn) eng_err);
    c_transfer_done: cover property (@(posedge ref_clk) disable iff (!resetn) tc_ev);
    c_half_write: cover property (@(posedge ref_clk) disable iff (!resetn)
        (m_htrans == DCS_HTRANS_NONSEQ) && m_hwrite && (m_hsize == DCS_HSIZE_HALF));
    c_narrow_reg: cover property (@(posedge ref_clk) disable iff (!resetn) slv_take && slv_bad);
endmodule // dcs_dma_top

//--- dcs_pkg.sv
// Shared constants, types and helpers for the DMA channel status block
package dcs_pkg;
    // Register offsets
    localparam logic [7:0] DCS_OFF_STATUS = 8'h00;
    localparam logic [7:0] DCS_OFF_CLEAR = 8'h04;
    localparam logic [7:0] DCS_OFF_REQSEL = 8'h08;
    localparam logic [3:0] DCS_CH_FIRST_BLOCK = 4'h1;
    localparam logic [1:0] DCS_CH_REG_CCR = 2'h0;
    localparam logic [1:0] DCS_CH_REG_COUNT = 2'h1;
    localparam logic [1:0] DCS_CH_REG_SRC = 2'h2;
    localparam logic [1:0] DCS_CH_REG_DST = 2'h3;
    localparam logic [31:0] DCS_RESET_WORD = 32'h0000_0000;
    // Flag layout inside the status word
    localparam int DCS_FLAGS_PER_CH = 4;
    localparam int DCS_FLG_GLOBAL = 0;
    localparam int DCS_FLG_TC = 1;
    localparam int DCS_FLG_HT = 2;
    localparam int DCS_FLG_TE = 3;
    // Channel configuration bit positions
    localparam int DCS_CCR_EN = 0;
    localparam int DCS_CCR_TRANSFER_COMPLETE_IRQ_ENABLE = 1;
    localparam int DCS_CCR_HALF_TRANSFER_IRQ_ENABLE = 2;
    localparam int DCS_CCR_TRANSFER_ERROR_IRQ_ENABLE = 3;
    localparam int DCS_CCR_SRC_INC = 4;
    localparam int DCS_CCR_DST_INC = 5;
    localparam int DCS_CCR_SRC_SIZE = 8;
    localparam int DCS_CCR_DST_SIZE = 10;
    localparam int DCS_CCR_MEM2MEM = 14;
    // Bus encodings
    localparam logic [2:0] DCS_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] DCS_HSIZE_HALF = 3'h1;
    localparam logic [2:0] DCS_HSIZE_WORD = 3'h2;
    localparam logic [1:0] DCS_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] DCS_HTRANS_NONSEQ = 2'h2;
    localparam logic DCS_HRESP_OKAY = 1'b0;
    localparam logic DCS_HRESP_ERROR = 1'b1;

    typedef struct packed {
        logic mem2mem;
        logic [1:0] dst_size;
        logic [1:0] src_size;
        logic dst_inc;
        logic src_inc;
        logic transfer_error_irq_enable;
        logic half_transfer_irq_enable;
        logic transfer_complete_irq_enable;
        logic en;
    } dcs_ccr_type;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } dcs_slv_phase_type;

    typedef enum logic [2:0] {ST_IDLE, ST_RD_ADDR, ST_RD_DATA, ST_WR_ADDR, ST_WR_DATA} dcs_eng_state_type;

    // Address step of one item of the given port width
    function automatic logic [31:0] dcs_size_bytes(input logic [1:0] size);
        case (size)
            2'h0: dcs_size_bytes = 32'h1;
            2'h1: dcs_size_bytes = 32'h2;
            default: dcs_size_bytes = 32'h4;
        endcase
    endfunction

    // Bit index of a flag of a channel
    function automatic int dcs_flag_pos(input int ch, input int flg);
        dcs_flag_pos = ch * DCS_FLAGS_PER_CH + flg;
    endfunction
endpackage

//--- dcs_fifo.sv
// Item FIFO between the read and write phases of the engine
`timescale 1ns/10ps
module dcs_fifo import dcs_pkg::*; #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input logic ref_clk,
    input logic resetn,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] level_r;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (level_r != FULL_LEVEL);
    assign out_valid = (level_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    // Storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                level_r <= level_r + 1'b1;
            end else if (pop && !push) begin
                level_r <= level_r - 1'b1;
            end
        end
    end
endmodule // dcs_fifo

//--- dcs_lane_dup.sv
// Copies a narrow write item onto every lane of the write data bus
`timescale 1ns/10ps
module dcs_lane_dup import dcs_pkg::*; (
    input logic [2:0] size,
    input logic [31:0] item,
    output logic [31:0] lanes
);
    // Duplicate by write size, upper bits of a wider item are dropped
    always_comb begin
        case (size)
            DCS_HSIZE_BYTE: lanes = {4{item[7:0]}};
            DCS_HSIZE_HALF: lanes = {2{item[15:0]}};
            default: lanes = item;
        endcase
    end
endmodule // dcs_lane_dup

//--- dcs_mem_model.sv
// AHB slave model of memory on the DMA master port
`timescale 1ns/10ps
module dcs_mem_model import dcs_pkg::*; (
    input logic ref_clk,
    input logic resetn,
    input logic [31:0] m_haddr,
    input logic [1:0] m_htrans,
    input logic m_hwrite,
    input logic [2:0] m_hsize,
    input logic [31:0] m_hwdata,
    output logic m_hready,
    output logic m_hresp,
    output logic [31:0] m_hrdata,
    output logic [42:0] wlast,
    output logic [7:0] wcnt
);
    logic dph_r, bad_r, wr_r, first_r;
    logic [2:0] sz_r;
    logic [7:0] a_r;
    // Two-cycle error on reserved space; idle read lines inverted
    assign m_hready = !(dph_r && bad_r && first_r);
    assign m_hresp = dph_r && bad_r;
    assign m_hrdata = {4{a_r}} ^ (dph_r ? 32'h1122_33ab : 32'heedd_cc54);
    // Address capture and write record
    always_ff @(posedge ref_clk) begin
        first_r <= m_hready;
        if (!resetn) begin
            {dph_r, wcnt} <= 9'h0;
        end else if (m_hready) begin
            {dph_r, bad_r} <= {m_htrans[1], m_haddr[31:28] != 4'h0};
            {a_r, wr_r, sz_r} <= {m_haddr[7:0], m_hwrite, m_hsize};
            if (dph_r && !bad_r && wr_r) begin
                wlast <= {a_r, m_hwdata, sz_r};
                wcnt <= wcnt + 8'h1;
            end
        end
    end
endmodule // dcs_mem_model

//--- dcs_dma_top_tb_top.sv
// Self-checking bench for the DMA channel status block
`timescale 1ns/10ps
`define CHK(n,e,g) begin num_checks++; if ((g)!==(e)) begin failures++; $display("[ERR] %s exp %h got %h",n,e,g); end end
module dcs_dma_top_tb_top import dcs_pkg::*;;
    logic ref_clk = 1'b0, resetn = 1'b0, s_hsel = 1'b0, s_hwrite = 1'b0, adc_req = 1'b0;
    logic s_hreadyout, s_hresp, m_hwrite, m_hready, m_hresp;
    logic [1:0] s_htrans = 2'h0, m_htrans;
    logic [2:0] s_hsize = 3'h2, m_hsize;
    logic [7:0] periph_req = 8'h0, chan_irq, wcnt;
    logic [31:0] s_haddr = 32'h0, s_hwdata = 32'h0, s_hrdata, m_haddr, m_hwdata, m_hrdata, rd;
    logic [42:0] wlast;
    logic rsp;
    int failures = 0, num_checks = 0, cyc = 0;
    dcs_dma_top u_dut (.*, .s_hready(s_hreadyout));
    dcs_mem_model u_mem (.*);
    // Clock and hang ceiling
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 2000) begin
        failures++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Register access: address phase, then data phase
    task automatic ahb(input logic [7:0] a, input logic [31:0] d, input logic wr = 1'b1, input logic [2:0] sz = 3'h2);
        @(posedge ref_clk) #1;
        {s_hsel, s_htrans, s_hwrite, s_hsize, s_haddr} = {1'b1, 2'h2, wr, sz, 24'h0, a};
        @(posedge ref_clk) #1;
        {s_hsel, s_htrans, s_hwdata} = {3'h0, d};
        // Data phase ends at the edge that samples ready high
        do @(posedge ref_clk); while (s_hreadyout !== 1'b1 && cyc < 1990);
        {rd, rsp} = {s_hrdata, s_hresp};
        #1;
    endtask
    task automatic cfg(input logic [7:0] b, input logic [31:0] cnt, src, dst, ccr);
        ahb(b + 8'h4, cnt);
        ahb(b + 8'h8, src);
        ahb(b + 8'hc, dst);
        ahb(b, ccr);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(a, 32'h0, 1'b0);
        `CHK("read", e, rd)
    endtask
    // Register map, three channel transfers, flag clearing
    initial begin
        repeat (6) @(posedge ref_clk) #1;
        resetn = 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        ahb(8'h00, 32'h0, 1'b0, 3'h0);
        `CHK("byte resp", 1'b1, rsp)
        cfg(8'h10, 32'h2, 32'h0, 32'h40, 32'h4237);
        wait (wcnt === 8'h2) repeat (4) @(posedge ref_clk) #1;
        `CHK("byte lanes", {8'h41, 32'hafaf_afaf, DCS_HSIZE_BYTE}, wlast)
        rd_chk(8'h00, 32'h7);
        `CHK("irq", 8'h01, chan_irq)
        ahb(8'h08, 32'h2);
        ahb(8'h08, 32'hff, 1'b1, 3'h1);
        `CHK("half resp", 1'b1, rsp)
        rd_chk(8'h08, 32'h2);
        cfg(8'h20, 32'h1, 32'h8, 32'h50, 32'h0503);
        periph_req = 8'h02;
        repeat (20) @(posedge ref_clk) #1;
        `CHK("idle", 8'h2, wcnt)
        adc_req = 1'b1;
        wait (wcnt === 8'h3) repeat (4) @(posedge ref_clk) #1;
        `CHK("half lanes", {8'h50, 32'h3ba3_3ba3, DCS_HSIZE_HALF}, wlast)
        cfg(8'h30, 32'h1, 32'hf000_0000, 32'h60, 32'h4a09);
        repeat (30) @(posedge ref_clk) #1;
        `CHK("irq", 8'h07, chan_irq)
        rd_chk(8'h30, 32'h4a08);
        ahb(8'h04, 32'hf07);
        ahb(8'h00, 32'hffff_ffff);
        rd_chk(8'h00, 32'h30);
        `CHK("irq", 8'h02, chan_irq)
        tally_and_finish();
    end
endmodule // dcs_dma_top_tb_top
